// ### pcm_companding_word_port.sv
// digital side of a single-channel companding pcm codec
// Contract
// - mu-law word is the sign then the seven magnitude bits inverted
// - a-law word has every even-numbered bit inverted before sending
// - mu-law negative code between 127 and 128 goes out as 00000010
// - with suppression on in mu-law mode, never more than fifteen zero bits in a row
// - transmit shift clock, 64 kHz to 2.048 MHz, shifts each word out
// - receive shift clock shifts one word into the buffer per frame
// - one transmit sample per 8 kHz sampling period, one word per frame
// - encoding takes nine and a half converter cycles, about 72 us
// - transmit and receive timing are fully independent
`include "pcm_port_defs.svh"

module pcm_companding_word_port #(
   parameter int FRAME_CYCLES =
      (`PCM_FRAME_NS + `PCM_CLK_NS - 1) / `PCM_CLK_NS,
   parameter int CONV_CYCLES =
      (`PCM_CONV_NS + `PCM_CLK_NS - 1) / `PCM_CLK_NS
) (
   input logic clk,
   input logic reset_n,
   input logic lawSelA,
   input logic zeroSuppressEn,
   input pcm_port_pkg::pcm_sample_t txSample,
   output logic txSampleTaken,
   output logic txSampleSkipped,
   input logic txShiftClk,
   input logic txSlotEn,
   output logic txSerialOut,
   output logic txSerialOe,
   input logic rxShiftClk,
   input logic rxSlotEn,
   input logic rxSerialIn,
   output pcm_port_pkg::pcm_sample_t rxSample,
   output logic rxSampleValid,
   input logic rxSampleReady,
   output logic rxOverrun
);

   // ****************************************
   // elaboration checks and derived counts
   // ****************************************
   generate
      if (FRAME_CYCLES < 2 || FRAME_CYCLES > 65536) begin : g_bad_frame
         $error("FRAME_CYCLES must lie in 2..65536");
      end
      if (CONV_CYCLES < 1 || CONV_CYCLES >= FRAME_CYCLES) begin : g_bad_conv
         $error("CONV_CYCLES must be at least 1 and below FRAME_CYCLES");
      end
   endgenerate

   localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
   localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

   // ****************************************
   // word formatting
   // ****************************************

   // inversion pattern of the selected law; xor is its own inverse,
   // so the same mask serves both directions
   function automatic logic [7:0] lawMask(input logic aLaw);
      lawMask = aLaw ? `PCM_A_MASK : `PCM_MU_MASK;
   endfunction : lawMask

   // companded sample to line word
   function automatic logic [7:0] encodeWord(
      input pcm_port_pkg::pcm_sample_t s,
      input logic aLaw,
      input logic suppress
   );
      logic [7:0] w;
      w = {s.sign, s.mag} ^ lawMask(aLaw);
      // an all-zero mu-law word starves line clock recovery
      if (!aLaw && suppress && w == `PCM_ZERO_WORD) begin
         w = `PCM_ZERO_SUB;
      end
      encodeWord = w;
   endfunction : encodeWord

   // line word back to a companded sample
   function automatic pcm_port_pkg::pcm_sample_t decodeWord(
      input logic [7:0] w,
      input logic aLaw
   );
      decodeWord = pcm_port_pkg::pcm_sample_t'(w ^ lawMask(aLaw));
   endfunction : decodeWord

   // ****************************************
   // state records of the three domains
   // ****************************************
   pcm_port_pkg::core_state_t cReg;
   pcm_port_pkg::core_state_t cNext;
   pcm_port_pkg::tx_link_state_t tReg;
   pcm_port_pkg::tx_link_state_t tNext;
   pcm_port_pkg::rx_link_state_t rReg;
   pcm_port_pkg::rx_link_state_t rNext;

   logic frameTick;
   logic txFree;
   logic txBufInValid;
   logic txBufInReady;
   logic txBufOutValid;
   logic txBufOutReady;
   logic [7:0] txBufOut;
   logic rxBufInReady;
   logic [7:0] rxBufOut;

   // ****************************************
   // transmit side buffer: converter to link
   // ****************************************

   // a slow or absent transmit slot stalls the converter, not the data
   pcm_pair_buffer #(
      .WIDTH(`PCM_WORD_W)
   ) txBuf (
      .clk(clk),
      .reset_n(reset_n),
      .inValid(txBufInValid),
      .inReady(txBufInReady),
      .inData(cReg.convWord),
      .outValid(txBufOutValid),
      .outReady(txBufOutReady),
      .outData(txBufOut)
   );

   // ****************************************
   // receive side buffer: link to user
   // ****************************************
   pcm_pair_buffer #(
      .WIDTH(`PCM_WORD_W)
   // a stalled reader backs up into the pending word, then words drop
   ) rxBuf (
      .clk(clk),
      .reset_n(reset_n),
      .inValid(cReg.rxPend),
      .inReady(rxBufInReady),
      .inData(cReg.rxPendWord),
      .outValid(rxSampleValid),
      .outReady(rxSampleReady),
      .outData(rxBufOut)
   );

   // buffer word seen again as sign and magnitude
   assign rxSample = pcm_port_pkg::pcm_sample_t'(rxBufOut);

   // ****************************************
   // core domain: frame timer, converter, crossings
   // ****************************************
   // frame pulse and hand-over gate; a word goes to the link only once
   // the link has acknowledged the last one, so the toggle never
   // runs more than one step ahead of its synchroniser
   assign frameTick = (cReg.frameCnt == FRAME_LAST);
   assign txFree = (cReg.txReq == cReg.ackSync);
   assign txBufOutReady = txFree;

   always_comb begin
      cNext = cReg;
      cNext.taken = 1'b0;
      cNext.skipped = 1'b0;
      cNext.overrun = 1'b0;
      txBufInValid = 1'b0;

      // free-running sampling period, one sample each
      if (frameTick) begin
         cNext.frameCnt = 16'h0000;
      end else begin
         cNext.frameCnt = cReg.frameCnt + 16'h0001;
      end

      // converter sequence
      unique case (cReg.conv)
         pcm_port_pkg::CONV_IDLE: begin
            if (frameTick) begin
               cNext.convWord =
                  encodeWord(txSample, lawSelA, zeroSuppressEn);
               cNext.convCnt = 16'h0000;
               cNext.conv = pcm_port_pkg::CONV_BUSY;
               cNext.taken = 1'b1;
            end
         end
         pcm_port_pkg::CONV_BUSY: begin
            // the word is not offered until conversion time has run
            if (cReg.convCnt == CONV_LAST) begin
               cNext.conv = pcm_port_pkg::CONV_PUSH;
            end else begin
               cNext.convCnt = cReg.convCnt + 16'h0001;
            end
         end
         pcm_port_pkg::CONV_PUSH: begin
            txBufInValid = 1'b1;
            if (txBufInReady) begin
               cNext.conv = pcm_port_pkg::CONV_IDLE;
            end
         end
         default: begin
            cNext.conv = pcm_port_pkg::CONV_IDLE;
         end
      endcase

      // a frame that finds the converter stalled loses its sample
      if (frameTick && cReg.conv != pcm_port_pkg::CONV_IDLE) begin
         cNext.skipped = 1'b1;
      end

      // hand a word to the transmit link once the last one was taken;
      // txWord stays still until the link acknowledges it
      if (txFree && txBufOutValid) begin
         cNext.txWord = txBufOut;
         cNext.txReq = ~cReg.txReq;
      end
      cNext.ackMeta = tReg.reqSeen;
      cNext.ackSync = cReg.ackMeta;

      // receive word event, toggle synchronised in two stages
      cNext.rxMeta = rReg.tog;
      cNext.rxSync = cReg.rxMeta;
      cNext.rxSeen = cReg.rxSync;
      if (cReg.rxPend && rxBufInReady) begin
         cNext.rxPend = 1'b0;
      end
      // the link word register holds for a whole frame, long enough
      // to be read here after the toggle settles
      if (cReg.rxSync != cReg.rxSeen) begin
         if (cNext.rxPend) begin
            cNext.overrun = 1'b1;
         end else begin
            cNext.rxPend = 1'b1;
            cNext.rxPendWord = decodeWord(rReg.word, lawSelA);
         end
      end
   end

   // core record; reset leaves the idle word in both word holders,
   // so anything read before the first conversion is all ones and
   // the line never sees a long run of zeros after start-up
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cReg <= '{
            conv: pcm_port_pkg::CONV_IDLE,
            convWord: `PCM_IDLE_WORD,
            txWord: `PCM_IDLE_WORD,
            default: '0
         };
      end else begin
         cReg <= cNext;
      end
   end

   // status pulses straight from flops
   assign txSampleTaken = cReg.taken;
   assign txSampleSkipped = cReg.skipped;
   assign rxOverrun = cReg.overrun;

   // ****************************************
   // transmit link domain
   // ****************************************

   // bit sequencer: the first slot edge loads the sign bit, the next
   // seven shift the rest; the pin is only driven inside a slot
   always_comb begin
      logic [7:0] w;
      w = `PCM_IDLE_WORD;
      tNext = tReg;
      tNext.reqMeta = cReg.txReq;
      tNext.reqSync = tReg.reqMeta;

      // slot framing; an empty hold sends the idle word
      if (!txSlotEn) begin
         tNext.bitCnt = 4'h0;
         tNext.serOe = 1'b0;
      end else if (tReg.bitCnt == 4'h0) begin
         if (tReg.holdFull) begin
            w = tReg.holdWord;
         end
         tNext.serOut = w[7];
         tNext.shift = {w[6:0], 1'b0};
         tNext.bitCnt = 4'h1;
         tNext.serOe = 1'b1;
         tNext.holdFull = 1'b0;
      end else if (tReg.bitCnt < `PCM_BITS_PER_WORD) begin
         tNext.serOut = tReg.shift[7];
         tNext.shift = {tReg.shift[6:0], 1'b0};
         tNext.bitCnt = tReg.bitCnt + 4'h1;
      end else begin
         tNext.serOe = 1'b0;
      end

      // take a new word only into an empty hold: the ack is held back
      // otherwise, so the core side cannot overwrite a pending word
      if (tReg.reqSync != tReg.reqSeen && !tNext.holdFull) begin
         tNext.holdWord = cReg.txWord;
         tNext.holdFull = 1'b1;
         tNext.reqSeen = tReg.reqSync;
      end
   end

   // runs on the highway's transmit clock; its rate is free within
   // the allowed range because nothing here counts core cycles
   always_ff @(posedge txShiftClk or negedge reset_n) begin
      if (!reset_n) begin
         tReg <= '{
            holdWord: `PCM_IDLE_WORD,
            shift: `PCM_IDLE_WORD,
            default: '0
         };
      end else begin
         tReg <= tNext;
      end
   end

   // pin and enable straight from flops, so neither can glitch
   assign txSerialOut = tReg.serOut;
   assign txSerialOe = tReg.serOe;

   // ****************************************
   // receive link domain
   // ****************************************

   // only eight edges of a slot count; extra ones are ignored
   always_comb begin
      rNext = rReg;
      if (!rxSlotEn) begin
         rNext.bitCnt = 4'h0;
      end else if (rReg.bitCnt < `PCM_BITS_PER_WORD) begin
         rNext.shift = {rReg.shift[6:0], rxSerialIn};
         rNext.bitCnt = rReg.bitCnt + 4'h1;
         if (rReg.bitCnt == `PCM_BITS_PER_WORD - 4'h1) begin
            rNext.word = {rReg.shift[6:0], rxSerialIn};
            rNext.tog = ~rReg.tog;
         end
      end
   end

   // runs on the highway's receive clock, unrelated to the transmit one
   // so the two directions may sit in different time slots
   always_ff @(posedge rxShiftClk or negedge reset_n) begin
      if (!reset_n) begin
         rReg <= '0;
      end else begin
         rReg <= rNext;
      end
   end

endmodule : pcm_companding_word_port

// ### pcm_highway_model.sv
// model of the pcm highway beside the word port
`include "pcm_port_defs.svh"
module pcm_highway_model (
   output logic txShiftClk,
   output logic txSlotEn,
   input logic txSerialOut,
   input logic txSerialOe,
   output logic rxShiftClk,
   output logic rxSlotEn,
   output logic rxSerialIn
);
   timeunit 1ns;
   timeprecision 100ps;
   logic txRun = 1'b1;
   logic capOk;
   logic [7:0] capWord;
   logic [7:0] lastWord = 8'hFF;

   // ****************************************
   // bit clocks
   // ****************************************
   // highway bit clocks run free, each on a phase of its own
   initial begin
      txShiftClk = 1'b0;
      #4;
      forever #15 txShiftClk = ~txShiftClk;
   end
   initial begin
      rxShiftClk = 1'b0;
      #11;
      forever #15 rxShiftClk = ~rxShiftClk;
   end

   // ****************************************
   // transmit slots
   // ****************************************
   // slot of eight shifts and a short gap; idle words are not recorded
   initial txSlotEn = 1'b0;
   always begin
      @(posedge txShiftClk);
      #1;
      txSlotEn = txRun;
      if (txRun) begin
         capOk = 1'b1;
         @(posedge txShiftClk);
         repeat (8) begin
            @(negedge txShiftClk);
            capWord = {capWord[6:0], txSerialOut};
            capOk = capOk & (txSerialOe === 1'b1);
            @(posedge txShiftClk);
         end
         #1;
         txSlotEn = 1'b0;
         if (capOk && capWord !== `PCM_IDLE_WORD) lastWord = capWord;
         repeat (3) @(posedge txShiftClk);
      end
   end

   // ****************************************
   // receive slots
   // ****************************************
   // a released line toggles so a stale bit never looks valid
   initial rxSlotEn = 1'b0;
   initial rxSerialIn = 1'b0;
   always @(posedge rxShiftClk) begin
      if (!rxSlotEn) rxSerialIn <= ~rxSerialIn;
   end

   task automatic sendWord(input logic [7:0] w);
      @(posedge rxShiftClk);
      #1;
      rxSlotEn = 1'b1;
      rxSerialIn = w[7];
      for (int i = 6; i >= 0; i--) begin
         @(posedge rxShiftClk);
         #1;
         rxSerialIn = w[i];
      end
      @(posedge rxShiftClk);
      #1;
      rxSlotEn = 1'b0;
      repeat (2) @(posedge rxShiftClk);
   endtask : sendWord
endmodule : pcm_highway_model

// ### pcm_pair_buffer.sv
// two-entry buffer with valid and ready on both sides
module pcm_pair_buffer #(
   parameter int WIDTH = 8
) (
   input logic clk,
   input logic reset_n,
   input logic inValid,
   output logic inReady,
   input logic [WIDTH-1:0] inData,
   output logic outValid,
   input logic outReady,
   output logic [WIDTH-1:0] outData
);

   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic rdPtr;
      logic wrPtr;
      logic [1:0] count;
   } buf_state_t;

   buf_state_t sReg;
   buf_state_t sNext;
   logic push;
   logic pop;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("pcm_pair_buffer: WIDTH must be at least 1");
      end
   endgenerate

   // full and empty come straight from the count
   assign inReady = (sReg.count != 2'h2);
   assign outValid = (sReg.count != 2'h0);
   assign outData = sReg.mem[sReg.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // pointers wrap naturally at depth two
   always_comb begin
      sNext = sReg;
      if (push) begin
         sNext.mem[sReg.wrPtr] = inData;
         sNext.wrPtr = ~sReg.wrPtr;
      end
      if (pop) begin
         sNext.rdPtr = ~sReg.rdPtr;
      end
      if (push && !pop) begin
         sNext.count = sReg.count + 2'h1;
      end else if (pop && !push) begin
         sNext.count = sReg.count - 2'h1;
      end
   end

   // one register stage for the whole buffer record
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sReg <= '0;
      end else begin
         sReg <= sNext;
      end
   end

endmodule : pcm_pair_buffer

// ### pcm_port_defs.svh
// constants for the companding pcm word port
`ifndef PCM_PORT_DEFS_SVH
`define PCM_PORT_DEFS_SVH

// ****************************************
// word format
// ****************************************
`define PCM_WORD_W 8
`define PCM_MU_MASK 8'h7F
`define PCM_A_MASK 8'h55
`define PCM_ZERO_SUB 8'h02
`define PCM_ZERO_WORD 8'h00
`define PCM_IDLE_WORD 8'hFF
`define PCM_BITS_PER_WORD 4'h8

// ****************************************
// timing
// ****************************************
`define PCM_CLK_NS 10
`define PCM_FRAME_NS 125000
`define PCM_CONV_NS 72000

`endif

// ### pcm_port_pkg.sv
// types shared by the companding pcm word port
package pcm_port_pkg;

   // ****************************************
   // sample as the converter sees it
   // ****************************************
   typedef struct packed {
      logic sign;
      logic [6:0] mag;
   } pcm_sample_t;

   typedef enum logic [2:0] {
      CONV_IDLE = 3'b001,
      CONV_BUSY = 3'b010,
      CONV_PUSH = 3'b100
   } conv_state_t;

   // ****************************************
   // per-domain state records
   // ****************************************
   typedef struct packed {
      logic [15:0] frameCnt;
      logic [15:0] convCnt;
      conv_state_t conv;
      logic [7:0] convWord;
      logic [7:0] txWord;
      logic txReq;
      logic ackMeta;
      logic ackSync;
      logic rxMeta;
      logic rxSync;
      logic rxSeen;
      logic rxPend;
      logic [7:0] rxPendWord;
      logic taken;
      logic skipped;
      logic overrun;
   } core_state_t;

   typedef struct packed {
      logic reqMeta;
      logic reqSync;
      logic reqSeen;
      logic holdFull;
      logic [7:0] holdWord;
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic serOut;
      logic serOe;
   } tx_link_state_t;

   typedef struct packed {
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic [7:0] word;
      logic tog;
   } rx_link_state_t;

endpackage : pcm_port_pkg

// ### pcm_port_sva.sv
// assertions for the companding pcm word port
module pcm_port_sva #(
   parameter int FRAME_CYCLES = 80
) (
   input logic clk,
   input logic reset_n,
   input logic txSampleTaken,
   input logic txSampleSkipped,
   input logic txShiftClk,
   input logic txSlotEn,
   input logic txSerialOe,
   input pcm_port_pkg::pcm_sample_t rxSample,
   input logic rxSampleValid,
   input logic rxSampleReady,
   input logic rxOverrun
);
   // ****************************************
   // frame spacing helper
   // ****************************************
   logic [15:0] tickGap_reg;
   logic seen_reg;

   // cycles since the last frame pulse; the first pulse only arms the check
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tickGap_reg <= 16'h0000;
         seen_reg <= 1'b0;
      end else if (txSampleTaken || txSampleSkipped) begin
         tickGap_reg <= 16'h0000;
         seen_reg <= 1'b1;
      end else begin
         tickGap_reg <= tickGap_reg + 16'h0001;
      end
   end

   // ****************************************
   // properties
   // ****************************************
   // a driven word is eight bit times and then the pin is released
   sequence s_txBurst;
      txSerialOe [*8] ##1 !txSerialOe;
   endsequence

   a_frame_period: assert property (@(posedge clk) disable iff (!reset_n)
      seen_reg && (txSampleTaken || txSampleSkipped)
      |-> tickGap_reg == FRAME_CYCLES - 1) else $error("frame spacing off");
   a_taken_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      txSampleTaken |=> !txSampleTaken) else $error("taken too long");
   a_take_or_skip: assert property (@(posedge clk) disable iff (!reset_n)
      txSampleSkipped |-> !txSampleTaken) else $error("taken and skipped");
   a_tx_burst: assert property (@(posedge txShiftClk) disable iff (!reset_n)
      $rose(txSerialOe) |-> s_txBurst) else $error("burst length wrong");
   a_slot_gate: assert property (@(posedge txShiftClk) disable iff (!reset_n)
      $rose(txSerialOe) |-> $past(txSlotEn)) else $error("drive without slot");
   a_slot_release: assert property (@(posedge txShiftClk)
      disable iff (!reset_n) !txSlotEn |=> !txSerialOe)
      else $error("pin held after slot");
   a_overrun_full: assert property (@(posedge clk) disable iff (!reset_n)
      rxOverrun |-> rxSampleValid) else $error("overrun with room left");
   a_rx_hold: assert property (@(posedge clk) disable iff (!reset_n)
      rxSampleValid && !rxSampleReady |=> rxSampleValid && $stable(rxSample))
      else $error("receive word not held");
endmodule : pcm_port_sva

bind pcm_companding_word_port pcm_port_sva #(
   .FRAME_CYCLES(FRAME_CYCLES)
) u_sva (
   .clk(clk), .reset_n(reset_n), .txSampleTaken(txSampleTaken),
   .txSampleSkipped(txSampleSkipped), .txShiftClk(txShiftClk),
   .txSlotEn(txSlotEn), .txSerialOe(txSerialOe), .rxSample(rxSample),
   .rxSampleValid(rxSampleValid), .rxSampleReady(rxSampleReady),
   .rxOverrun(rxOverrun)
);

// ### test_pcm_companding_word_port.sv
// self-checking bench for the companding pcm word port
`include "pcm_port_defs.svh"
module test_pcm_companding_word_port;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int FRAME = 80;
   logic clk = 1'b0;
   logic reset_n, lawSelA, zeroSuppressEn, rxSampleReady;
   logic txSampleTaken, txSampleSkipped, txShiftClk, txSlotEn;
   logic txSerialOut, txSerialOe, rxShiftClk, rxSlotEn, rxSerialIn;
   logic rxSampleValid, rxOverrun;
   pcm_port_pkg::pcm_sample_t txSample, rxSample;
   int error_cnt = 0, n_tests = 0, ovCnt = 0, skipCnt = 0;

   pcm_companding_word_port #(.FRAME_CYCLES(FRAME), .CONV_CYCLES(10)) u_dut (
      .clk(clk), .reset_n(reset_n), .lawSelA(lawSelA),
      .zeroSuppressEn(zeroSuppressEn), .txSample(txSample),
      .txSampleTaken(txSampleTaken), .txSampleSkipped(txSampleSkipped),
      .txShiftClk(txShiftClk), .txSlotEn(txSlotEn),
      .txSerialOut(txSerialOut), .txSerialOe(txSerialOe),
      .rxShiftClk(rxShiftClk), .rxSlotEn(rxSlotEn), .rxSerialIn(rxSerialIn),
      .rxSample(rxSample), .rxSampleValid(rxSampleValid),
      .rxSampleReady(rxSampleReady), .rxOverrun(rxOverrun));
   pcm_highway_model u_hw (
      .txShiftClk(txShiftClk), .txSlotEn(txSlotEn), .txSerialOut(txSerialOut),
      .txSerialOe(txSerialOe), .rxShiftClk(rxShiftClk), .rxSlotEn(rxSlotEn),
      .rxSerialIn(rxSerialIn));

   // core clock and pulse counters
   always #5 clk = ~clk;
   always @(negedge clk) begin
      if (rxOverrun === 1'b1) ovCnt++;
      if (txSampleSkipped === 1'b1) skipCnt++;
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   // expected line word, worked out independently of the design
   function automatic logic [7:0] expWord(input logic a, input logic s,
                                          input logic [7:0] v);
      logic [7:0] w;
      w = v ^ (a ? `PCM_A_MASK : `PCM_MU_MASK);
      if (!a && s && w == `PCM_ZERO_WORD) w = `PCM_ZERO_SUB;
      return w;
   endfunction : expWord

   task automatic setTx(input logic a, input logic s, input logic [7:0] v);
      @(posedge clk);
      #1;
      lawSelA = a;
      zeroSuppressEn = s;
      txSample = v;
   endtask : setTx

   // bounded so a missing pulse cannot hang the run
   task automatic waitTaken;
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (txSampleTaken !== 1'b1 && n < 4 * FRAME) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({7'h00, txSampleTaken}, 8'h01);
   endtask : waitTaken

   task automatic popCheck(input logic [7:0] exp);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (rxSampleValid !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({7'h00, rxSampleValid}, 8'h01);
      check(rxSample, exp);
      rxSampleReady = 1'b1;
      @(posedge clk);
      #1;
      rxSampleReady = 1'b0;
   endtask : popCheck

   // ****************************************
   // scenarios
   // ****************************************
   // each law and suppression setting, with an asymmetric pattern for order
   task automatic testTxFormat;
      logic [9:0] cases [5];
      logic [7:0] e;
      cases = '{10'h17F, 10'h07F, 10'h1A5, 10'h37F, 10'h280};
      foreach (cases[i]) begin
         setTx(cases[i][9], cases[i][8], cases[i][7:0]);
         e = expWord(cases[i][9], cases[i][8], cases[i][7:0]);
         repeat (2) waitTaken();
         repeat (100) @(posedge clk);
         check(u_hw.lastWord, e);
      end
      $display("test txFormat done");
   endtask : testTxFormat

   // highway stops reading: samples are refused, queued words survive
   task automatic testTxStall;
      int s0;
      s0 = skipCnt;
      setTx(1'b0, 1'b0, 8'h5A);
      u_hw.txRun = 1'b0;
      repeat (8 * FRAME) @(posedge clk);
      check({7'h00, skipCnt > s0}, 8'h01);
      u_hw.txRun = 1'b1;
      repeat (3 * FRAME) @(posedge clk);
      check(u_hw.lastWord, expWord(1'b0, 1'b0, 8'h5A));
      $display("test txStall done");
   endtask : testTxStall

   // reader stalls over four words: two buffered, one pending, one dropped
   task automatic testRxPath;
      logic [7:0] w [4];
      int o0;
      w = '{8'h81, 8'h3C, 8'hE7, 8'h00};
      setTx(1'b0, 1'b1, 8'h5A);
      o0 = ovCnt;
      foreach (w[i]) u_hw.sendWord(w[i]);
      repeat (20) @(posedge clk);
      check(8'(ovCnt - o0), 8'h01);
      for (int i = 0; i < 3; i++) popCheck(w[i] ^ `PCM_MU_MASK);
      repeat (4) @(posedge clk);
      check({7'h00, rxSampleValid}, 8'h00);
      setTx(1'b1, 1'b0, 8'h00);
      u_hw.sendWord(8'hC3);
      popCheck(8'hC3 ^ `PCM_A_MASK);
      $display("test rxPath done");
   endtask : testRxPath

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      reset_n = 1'b0;
      lawSelA = 1'b0;
      zeroSuppressEn = 1'b0;
      txSample = 8'h00;
      rxSampleReady = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      reset_n = 1'b1;
      testTxFormat();
      testTxStall();
      testRxPath();
      conclude();
   end

   // the tests need about 23 us; four times that means a hang
   initial begin
      #100000;
      error_cnt++;
      $display("ERROR t=%0t watchdog seen=%h exp=%h", $time, 1'b0, 1'b1);
      conclude();
   end
endmodule : test_pcm_companding_word_port
